// *** verilog/vpos_regs.svh ***
`ifndef VPOS_REGS_SVH
`define VPOS_REGS_SVH

// core clock and vector clock rates, in MHz
`define VPOS_CLK_MHZ 200
`define VPOS_F0_MHZ 1
`define VPOS_F1_MHZ 5
`define VPOS_F2_MHZ 10
`define VPOS_F3_MHZ 20
// half periods of the internal vector clock, in core cycles
`define VPOS_HALF0 (`VPOS_CLK_MHZ / (2 * `VPOS_F0_MHZ))
`define VPOS_HALF1 (`VPOS_CLK_MHZ / (2 * `VPOS_F1_MHZ))
`define VPOS_HALF2 (`VPOS_CLK_MHZ / (2 * `VPOS_F2_MHZ))
`define VPOS_HALF3 (`VPOS_CLK_MHZ / (2 * `VPOS_F3_MHZ))
`define VPOS_HCNT_W 8
// frequency select codes
`define VPOS_FSEL_1M 2'h0
`define VPOS_FSEL_5M 2'h1
`define VPOS_FSEL_10M 2'h2
`define VPOS_FSEL_20M 2'h3

// pattern memory geometry
`define VPOS_DEPTH 8192
`define VPOS_AW 13
`define VPOS_VEC_W 40
`define VPOS_FLG_W 4
`define VPOS_HI_W 12
`define VPOS_CNT_W 16
// entry flags, above the vector bits
`define VPOS_F_LSTART 0
`define VPOS_F_LEND 1
`define VPOS_F_WAIT 2
`define VPOS_F_LAST 3

// register byte offsets
`define VPOS_A_CTRL 8'h00
`define VPOS_A_STAT 8'h04
`define VPOS_A_MADR 8'h08
`define VPOS_A_MLO 8'h0C
`define VPOS_A_MHI 8'h10
`define VPOS_A_LOOP 8'h14
`define VPOS_A_PC 8'h18
// control fields
`define VPOS_C_START 0
`define VPOS_C_ABORT 1
`define VPOS_C_FREQ 2
`define VPOS_C_FREQ_W 2
`define VPOS_C_MODE 4
`define VPOS_C_DRPOL 5
`define VPOS_C_WPOL 6
`define VPOS_CTRL_RST 32'h0000_0020
`define VPOS_CTRL_MASK 32'h0000_007C
`define VPOS_LOOP_RST 16'h0001
// status fields
`define VPOS_S_DONE 0
`define VPOS_S_NOWAIT 1
`define VPOS_S_RUN 2
// bus lanes
`define VPOS_LANES 4
`define VPOS_LANE_W 8
// synchroniser slots
`define VPOS_SYNC_W 4
`define VPOS_Y_RISE 0
`define VPOS_Y_FALL 1
`define VPOS_Y_ACK 2
`define VPOS_Y_EN 3
`endif

// *** verilog/vpos_pkg.sv ***
`include "vpos_regs.svh"
package vpos_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RUN,
      ST_HOLD,
      ST_DONE
   } vpos_state_e;
   typedef logic [`VPOS_AW-1:0] vpos_addr_t;
endpackage

// *** verilog/vpos_sync.sv ***
`timescale 1ns/1ps
`include "vpos_regs.svh"
module vpos_sync (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // levels from other domains
   input wire logic [`VPOS_SYNC_W-1:0] async_in,
   output logic [`VPOS_SYNC_W-1:0] sync_out
);
   logic [`VPOS_SYNC_W-1:0] meta_q;

   // meta_q feeds only the second stage, never any logic
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// *** verilog/vpos_clkgen.sv ***
`timescale 1ns/1ps
`include "vpos_regs.svh"
module vpos_clkgen (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // rate select
   input wire logic [`VPOS_C_FREQ_W-1:0] freq_sel,
   // clock out and advance pulse
   output logic int_clk_out,
   output logic tick
);
   logic [`VPOS_HCNT_W-1:0] half_w;
   logic [`VPOS_HCNT_W-1:0] cnt_q;
   logic [`VPOS_C_FREQ_W-1:0] sel_q;
   logic wrap_w;

   // half period per selected rate
   always_comb begin
      case (freq_sel)
         `VPOS_FSEL_1M: half_w = `VPOS_HCNT_W'(`VPOS_HALF0);
         `VPOS_FSEL_5M: half_w = `VPOS_HCNT_W'(`VPOS_HALF1);
         `VPOS_FSEL_10M: half_w = `VPOS_HCNT_W'(`VPOS_HALF2);
         `VPOS_FSEL_20M: half_w = `VPOS_HCNT_W'(`VPOS_HALF3);
         default: half_w = `VPOS_HCNT_W'(`VPOS_HALF0);
      endcase
   end

   assign wrap_w = (cnt_q == half_w - `VPOS_HCNT_W'(1)) &&
                   (freq_sel == sel_q);
   // advance on the coming rising edge of the exported clock
   assign tick = wrap_w & ~int_clk_out;

   // free running: no start, stop or enable reaches here
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         sel_q <= `VPOS_FSEL_1M;
         int_clk_out <= 1'b0;
      end else begin
         sel_q <= freq_sel;
         if (freq_sel != sel_q) begin
            cnt_q <= '0;
         end else if (wrap_w) begin
            cnt_q <= '0;
            int_clk_out <= ~int_clk_out;
         end else begin
            cnt_q <= cnt_q + `VPOS_HCNT_W'(1);
         end
      end
   end
endmodule

// *** verilog/vpos_top.sv ***
`timescale 1ns/1ps
`include "vpos_regs.svh"
module vpos_top (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [`VPOS_LANES-1:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // link pins
   input wire logic external_drive_clock_in,
   input wire logic target_transfer_ack,
   input wire logic vector_enable,
   // pattern outputs
   output logic [`VPOS_VEC_W-1:0] vec_out,
   output logic address_advance_strobe,
   output logic int_clk_out
);
   localparam int ENT_W = `VPOS_VEC_W + `VPOS_FLG_W;

   logic rise_tgl_q;
   logic fall_tgl_q;
   logic [`VPOS_SYNC_W-1:0] sync_w;
   logic [`VPOS_SYNC_W-1:0] prev_q;
   logic rise_ev;
   logic fall_ev;
   logic ack_rise;
   logic ack_fall;
   logic en_s;
   logic tick_w;
   logic [31:0] wmask;
   logic req_w;
   logic wr_w;
   logic rd_w;
   logic hit_w;
   logic [7:0] adr_w;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [31:0] ctrl_q;
   logic [`VPOS_CNT_W-1:0] loop_q;
   vpos_pkg::vpos_addr_t madr_q;
   logic [31:0] mlo_q;
   logic [`VPOS_HI_W-1:0] mhi_q;
   logic [31:0] mhi_m;
   logic [ENT_W-1:0] mem_q [0:`VPOS_DEPTH-1];
   logic start_w;
   logic abort_w;
   logic start_ok;
   vpos_pkg::vpos_state_e st_q;
   vpos_pkg::vpos_addr_t pc_q;
   vpos_pkg::vpos_addr_t lstart_q;
   logic [`VPOS_CNT_W-1:0] iter_q;
   logic wpol_q;
   logic [ENT_W-1:0] ent_w;
   logic [`VPOS_FLG_W-1:0] flg_w;
   logic src_w;
   logic adv_w;
   logic last_w;
   logic rpt_w;
   logic hs_edge;
   logic [31:0] stat_w;
   logic [`VPOS_VEC_W-1:0] vec_q;
   logic strobe_q;

   // link domain: one toggle per rising edge of the drive clock
   always_ff @(posedge external_drive_clock_in or posedge rst) begin
      if (rst) begin
         rise_tgl_q <= 1'b0;
      end else begin
         rise_tgl_q <= ~rise_tgl_q;
      end
   end

   // falling edges counted apart so either polarity can be chosen
   always_ff @(negedge external_drive_clock_in or posedge rst) begin
      if (rst) begin
         fall_tgl_q <= 1'b0;
      end else begin
         fall_tgl_q <= ~fall_tgl_q;
      end
   end

   // everything from the pins enters through two flops
   vpos_sync u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in({vector_enable, target_transfer_ack,
                 fall_tgl_q, rise_tgl_q}),
      .sync_out(sync_w)
   );

   // edge detection on the synchronised copies
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prev_q <= '0;
      end else begin
         prev_q <= sync_w;
      end
   end

   assign rise_ev = sync_w[`VPOS_Y_RISE] ^ prev_q[`VPOS_Y_RISE];
   assign fall_ev = sync_w[`VPOS_Y_FALL] ^ prev_q[`VPOS_Y_FALL];
   assign ack_rise = sync_w[`VPOS_Y_ACK] & ~prev_q[`VPOS_Y_ACK];
   assign ack_fall = ~sync_w[`VPOS_Y_ACK] & prev_q[`VPOS_Y_ACK];
   assign en_s = sync_w[`VPOS_Y_EN];

   // internal vector clock, also driven out
   vpos_clkgen u_clkgen (
      .core_clk(core_clk),
      .rst(rst),
      .freq_sel(ctrl_q[`VPOS_C_FREQ +: `VPOS_C_FREQ_W]),
      .int_clk_out(int_clk_out),
      .tick(tick_w)
   );

   // byte lane mask from the select lines
   genvar gi;
   for (gi = 0; gi < `VPOS_LANES; gi++) begin : g_lane
      assign wmask[gi*`VPOS_LANE_W +: `VPOS_LANE_W] =
         {`VPOS_LANE_W{wb_sel_i[gi]}};
   end

   function automatic logic [31:0] mrg(input logic [31:0] old);
      mrg = (old & ~wmask) | (wb_dat_i & wmask);
   endfunction

   // bus decode; a request is taken on its first cycle only
   assign req_w = wb_cyc_i & wb_stb_i & ~ack_q;
   assign wr_w = req_w & wb_we_i;
   assign rd_w = req_w & ~wb_we_i;
   assign hit_w = (wb_adr_i[31:8] == '0);
   assign adr_w = hit_w ? wb_adr_i[7:0] : 8'hFF;
   assign mhi_m = mrg(32'(mhi_q));

   // single cycle acknowledge, also for unmapped addresses
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req_w;
      end
   end

   // start and abort are self-clearing command bits
   assign start_w = wr_w && (adr_w == `VPOS_A_CTRL) &&
                    wb_sel_i[0] && wb_dat_i[`VPOS_C_START];
   assign abort_w = wr_w && (adr_w == `VPOS_A_CTRL) &&
                    wb_sel_i[0] && wb_dat_i[`VPOS_C_ABORT];
   assign start_ok = start_w && !abort_w &&
      (st_q == vpos_pkg::ST_IDLE || st_q == vpos_pkg::ST_DONE);

   // configuration registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= `VPOS_CTRL_RST;
         loop_q <= `VPOS_LOOP_RST;
      end else if (wr_w) begin
         if (adr_w == `VPOS_A_CTRL) begin
            ctrl_q <= mrg(ctrl_q) & `VPOS_CTRL_MASK;
         end
         if (adr_w == `VPOS_A_LOOP) begin
            loop_q <= `VPOS_CNT_W'(mrg(32'(loop_q)));
         end
      end
   end

   // memory staging: a write of the high word commits the entry
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         madr_q <= '0;
         mlo_q <= '0;
         mhi_q <= '0;
      end else if (wr_w) begin
         if (adr_w == `VPOS_A_MADR) begin
            madr_q <= `VPOS_AW'(mrg(32'(madr_q)));
         end
         if (adr_w == `VPOS_A_MLO) begin
            mlo_q <= mrg(mlo_q);
         end
         if (adr_w == `VPOS_A_MHI) begin
            mhi_q <= mhi_m[`VPOS_HI_W-1:0];
            madr_q <= madr_q + `VPOS_AW'(1);
         end
      end
   end

   // pattern store; loading during a run is not blocked
   always_ff @(posedge core_clk) begin
      if (wr_w && adr_w == `VPOS_A_MHI) begin
         mem_q[madr_q] <= {mhi_m[`VPOS_HI_W-1:0], mlo_q};
      end
   end

   // status word
   always_comb begin
      stat_w = '0;
      stat_w[`VPOS_S_DONE] = (st_q == vpos_pkg::ST_DONE);
      stat_w[`VPOS_S_NOWAIT] = (st_q != vpos_pkg::ST_HOLD);
      stat_w[`VPOS_S_RUN] = (st_q == vpos_pkg::ST_RUN);
   end

   // read data, registered with the acknowledge
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (rd_w) begin
         case (adr_w)
            `VPOS_A_CTRL: rdata_q <= ctrl_q;
            `VPOS_A_STAT: rdata_q <= stat_w;
            `VPOS_A_MADR: rdata_q <= 32'(madr_q);
            `VPOS_A_MLO: rdata_q <= mlo_q;
            `VPOS_A_MHI: rdata_q <= 32'(mhi_q);
            `VPOS_A_LOOP: rdata_q <= 32'(loop_q);
            `VPOS_A_PC: rdata_q <= 32'(pc_q);
            default: rdata_q <= '0;
         endcase
      end
   end

   assign wb_dat_o = rdata_q;
   assign wb_ack_o = ack_q;

   // current entry and its advance conditions
   assign ent_w = mem_q[pc_q];
   assign flg_w = ent_w[`VPOS_VEC_W +: `VPOS_FLG_W];
   assign src_w = ctrl_q[`VPOS_C_MODE] ?
      (ctrl_q[`VPOS_C_DRPOL] ? rise_ev : fall_ev) : tick_w;
   // enable low freezes the sequencer where it stands
   assign adv_w = (st_q == vpos_pkg::ST_RUN) && src_w && en_s;
   assign last_w = flg_w[`VPOS_F_LAST] ||
      (pc_q == `VPOS_AW'(`VPOS_DEPTH - 1));
   assign rpt_w = flg_w[`VPOS_F_LEND] &&
      (iter_q + `VPOS_CNT_W'(1) < loop_q);
   assign hs_edge = wpol_q ? ack_rise : ack_fall;

   // wait polarity is caught at start and held for the run
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wpol_q <= 1'b1;
      end else if (start_ok) begin
         wpol_q <= ctrl_q[`VPOS_C_WPOL];
      end
   end

   // run state; a wait with no edge holds until an abort, by design
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q <= vpos_pkg::ST_IDLE;
      end else begin
         case (st_q)
            vpos_pkg::ST_IDLE: begin
               if (start_ok) begin
                  st_q <= vpos_pkg::ST_RUN;
               end
            end
            vpos_pkg::ST_RUN: begin
               if (abort_w) begin
                  st_q <= vpos_pkg::ST_IDLE;
               end else if (adv_w && last_w) begin
                  st_q <= vpos_pkg::ST_DONE;
               end else if (adv_w && flg_w[`VPOS_F_WAIT]) begin
                  st_q <= vpos_pkg::ST_HOLD;
               end
            end
            vpos_pkg::ST_HOLD: begin
               if (abort_w) begin
                  st_q <= vpos_pkg::ST_IDLE;
               end else if (hs_edge) begin
                  st_q <= vpos_pkg::ST_RUN;
               end
            end
            vpos_pkg::ST_DONE: begin
               if (abort_w) begin
                  st_q <= vpos_pkg::ST_IDLE;
               end else if (start_ok) begin
                  st_q <= vpos_pkg::ST_RUN;
               end
            end
            default: st_q <= vpos_pkg::ST_IDLE;
         endcase
      end
   end

   // vector address: sequential, or back to the loop start
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pc_q <= '0;
      end else if (start_ok) begin
         pc_q <= '0;
      end else if (adv_w && !last_w) begin
         pc_q <= rpt_w ? lstart_q : pc_q + `VPOS_AW'(1);
      end
   end

   // loop bookkeeping
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         iter_q <= '0;
         lstart_q <= '0;
      end else if (start_ok) begin
         iter_q <= '0;
         lstart_q <= '0;
      end else if (adv_w) begin
         if (flg_w[`VPOS_F_LSTART]) begin
            lstart_q <= pc_q;
         end
         if (flg_w[`VPOS_F_LEND]) begin
            iter_q <= rpt_w ? iter_q + `VPOS_CNT_W'(1) : '0;
         end
      end
   end

   // vector lines change only on an advance, else hold; the strobe pulses once per advance
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         vec_q <= '0;
         strobe_q <= 1'b0;
      end else begin
         strobe_q <= adv_w;
         if (adv_w) begin
            vec_q <= ent_w[`VPOS_VEC_W-1:0];
         end
      end
   end

   assign vec_out = vec_q;
   assign address_advance_strobe = strobe_q;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence s_read_stat;
      rd_w && adr_w == `VPOS_A_STAT;
   endsequence

   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   a_wb_ack_once: assert property (req_w |=> s_ack_pulse)
      else $error("ack not a single pulse after request");
   a_status_wait: assert property (s_read_stat |=>
      wb_dat_o[`VPOS_S_NOWAIT] == ($past(st_q) != vpos_pkg::ST_HOLD))
      else $error("status wait bit wrong");
   a_status_done: assert property (s_read_stat |=>
      wb_dat_o[`VPOS_S_DONE] == ($past(st_q) == vpos_pkg::ST_DONE))
      else $error("status done bit wrong");
   a_wpol_fixed: assert property (
      st_q != vpos_pkg::ST_IDLE && st_q != vpos_pkg::ST_DONE
      |=> $stable(wpol_q))
      else $error("wait polarity changed in a run");
   a_hold_edge: assert property (
      st_q == vpos_pkg::ST_HOLD && !abort_w
      |=> (st_q == vpos_pkg::ST_RUN) == $past(hs_edge))
      else $error("wait left without edge or edge missed");
   a_pause_hold: assert property (
      st_q == vpos_pkg::ST_RUN && !en_s && !start_ok
      |=> $stable(pc_q) && $stable(vec_out))
      else $error("advanced while enable inactive");
   a_drive_value: assert property (adv_w |=>
      vec_out == $past(ent_w[`VPOS_VEC_W-1:0]) &&
      address_advance_strobe)
      else $error("driven vector differs from store");
   a_loop_back: assert property (
      adv_w && !last_w && rpt_w && !start_ok
      |=> pc_q == $past(lstart_q))
      else $error("loop did not return to start");
   a_drclk_edge: assert property (
      st_q == vpos_pkg::ST_RUN && en_s && ctrl_q[`VPOS_C_MODE] &&
      ctrl_q[`VPOS_C_DRPOL] && rise_ev |-> adv_w)
      else $error("rising drive clock edge not used");
   a_hold_vec: assert property (
      st_q == vpos_pkg::ST_HOLD |=> $stable(vec_out))
      else $error("outputs changed while suspended");
   a_clk_spacing: assert property (
      tick_w |=> !tick_w [*8])
      else $error("internal clock faster than allowed");
endmodule

// *** bench/vpos_uut_model.sv ***
`timescale 1ns/1ps
module vpos_uut_model (
   // core clock, only for pacing the handshake and enable pins
   input wire logic core_clk,
   // link pins towards the sequencer
   output logic external_drive_clock_in,
   output logic target_transfer_ack,
   output logic vector_enable
);
   // drive clock parks low between frames, enable starts active
   initial begin
      external_drive_clock_in = 1'b0;
      target_transfer_ack = 1'b0;
      vector_enable = 1'b1;
   end

   // handshake level set right after a core edge, then one more edge waited
   task automatic hs(input logic lvl);
      @(posedge core_clk);
      target_transfer_ack <= lvl;
      @(posedge core_clk);
   endtask

   // external enable, changed right after a core edge
   task automatic set_en(input logic lvl);
      @(posedge core_clk);
      vector_enable <= lvl;
      @(posedge core_clk);
   endtask

   // one 64 ns drive-clock cycle per vector of the clocked program, so
   // a frame is as long as the clocking side's loop count; the odd
   // start offset keeps edges off the rising core clock edges
   task automatic frame(input int cnt);
      #3.5;
      repeat (cnt) begin
         external_drive_clock_in = 1'b1;
         #32;
         external_drive_clock_in = 1'b0;
         #32;
      end
   endtask
endmodule

// *** bench/vector_pattern_output_sequencer_tb.sv ***
`timescale 1ns/1ps
`include "vpos_regs.svh"
module vector_pattern_output_sequencer_tb;
   logic core_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, adr_hi;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd, r;
   logic [3:0] wb_sel_i, lanes;
   logic wb_ack_o, drclk, hs, en, strobe, int_clk;
   logic [`VPOS_VEC_W-1:0] vec_out;
   logic [`VPOS_VEC_W-1:0] exp_q[$];
   logic [`VPOS_VEC_W-1:0] v[5];
   int err_total = 0;
   int comparisons = 0;
   int nstb = 0;
   int n;
   int half[4] = '{100, 20, 10, 5};
   int seq[8] = '{0, 1, 2, 1, 2, 1, 2, 3};
   time t0;

   // core clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   vpos_top DUT (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .external_drive_clock_in(drclk),
      .target_transfer_ack(hs), .vector_enable(en), .vec_out(vec_out),
      .address_advance_strobe(strobe), .int_clk_out(int_clk));

   vpos_uut_model partner (.core_clk(core_clk),
      .external_drive_clock_in(drclk), .target_transfer_ack(hs),
      .vector_enable(en));

   task automatic chk(input logic [39:0] seen, input logic [39:0] expv);
      comparisons++;
      if (seen !== expv) begin
         err_total++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, expv);
      end
   endtask

   // each strobe consumes the oldest expected vector
   always @(posedge core_clk) begin
      if (strobe === 1'b1) begin
         nstb++;
         if (exp_q.size() == 0) chk(40'h0, 40'h1);
         else chk(vec_out, exp_q.pop_front());
      end
   end

   // one classic cycle; waits for ack as long as it takes, only the
   // watchdog ends a dead wait; ack is due one edge after the take
   task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d);
      int k;
      k = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {23'h0, adr_hi, a};
      wb_dat_i <= d;
      wb_sel_i <= lanes;
      @(posedge core_clk);
      while (wb_ack_o !== 1'b1) begin
         k++;
         @(posedge core_clk);
      end
      chk(40'(k), 40'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk({8'h0, rd}, {8'h0, e});
   endtask

   function automatic logic [31:0] ctl(input logic [1:0] f,
      input logic m, input logic p, input logic w, input logic s);
      return {25'h0, w, p, m, f, 1'b0, s};
   endfunction

   // random vectors, flags packed four bits per entry
   task automatic load(input int cnt, input logic [19:0] fl);
      wb(1'b1, `VPOS_A_MADR, 32'h0);
      for (int i = 0; i < cnt; i++) begin
         v[i][31:0] = $urandom;
         v[i][39:32] = 8'($urandom);
         wb(1'b1, `VPOS_A_MLO, v[i][31:0]);
         wb(1'b1, `VPOS_A_MHI, {20'h0, fl[4*i +: 4], v[i][39:32]});
      end
   endtask

   // polls status, bounded; the caller compares the last read
   task automatic wait_stat(input int b, input logic val);
      int k;
      k = 0;
      do begin
         wb(1'b0, `VPOS_A_STAT, 32'h0);
         k++;
      end while (rd[b] !== val && k < 400);
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // watchdog: the whole sequence needs well under this many cycles
   initial begin
      repeat (40000) @(posedge core_clk);
      err_total++;
      report_and_stop;
   end

   initial begin
      rst = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 32'h0;
      wb_dat_i = 32'h0;
      wb_sel_i = 4'h0;
      adr_hi = 1'b0;
      lanes = 4'hf;
      void'($urandom(48));
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rchk(`VPOS_A_CTRL, 32'h20);
      rchk(`VPOS_A_STAT, 32'h2);
      r = $urandom;
      adr_hi = 1'b1;
      wb(1'b1, `VPOS_A_LOOP, r);
      adr_hi = 1'b0;
      rchk(`VPOS_A_LOOP, 32'h1);
      rchk(8'h1c, 32'h0);
      wb(1'b1, `VPOS_A_LOOP, r);
      rchk(`VPOS_A_LOOP, {16'h0, r[15:0]});
      // random byte lanes: only selected lanes take the inverted data
      lanes = 4'($urandom);
      wb(1'b1, `VPOS_A_LOOP, ~r);
      r = r ^ {16'h0, {8{lanes[1]}}, {8{lanes[0]}}};
      lanes = 4'hf;
      rchk(`VPOS_A_LOOP, {16'h0, r[15:0]});
      $display("test registers done");
      // exported clock period per rate, enable toggled meanwhile
      for (int f = 0; f < 4; f++) begin
         wb(1'b1, `VPOS_A_CTRL, ctl(2'(f), 1'b0, 1'b1, 1'b0, 1'b0));
         partner.set_en(f[0]);
         @(posedge int_clk);
         t0 = $time;
         @(posedge int_clk);
         chk(40'(($time - t0) / 5), 40'(2 * half[f]));
         @(posedge core_clk);
      end
      partner.set_en(1'b1);
      $display("test clock done");
      // loop of three passes, pause, wait point, last entry
      load(5, 20'h8_4210);
      wb(1'b1, `VPOS_A_LOOP, 32'h3);
      for (int i = 0; i < 8; i++) exp_q.push_back(v[seq[i]]);
      wb(1'b1, `VPOS_A_CTRL, ctl(2'h3, 1'b0, 1'b1, 1'b0, 1'b1));
      wb(1'b1, `VPOS_A_CTRL, ctl(2'h3, 1'b0, 1'b1, 1'b1, 1'b0));
      repeat (15) @(posedge core_clk);
      partner.set_en(1'b0);
      repeat (10) @(posedge core_clk);
      n = nstb;
      repeat (200) @(posedge core_clk);
      chk(40'(nstb - n), 40'h0);
      partner.set_en(1'b1);
      wait_stat(1, 1'b0);
      chk({38'h0, rd[1:0]}, 40'h0);
      n = nstb;
      partner.hs(1'b1);
      repeat (100) @(posedge core_clk);
      chk(40'(nstb - n), 40'h0);
      chk(vec_out, v[3]);
      exp_q.push_back(v[4]);
      partner.hs(1'b0);
      wait_stat(0, 1'b1);
      chk({37'h0, rd[2:0]}, 40'h3);
      chk(40'(exp_q.size()), 40'h0);
      // abort takes a finished run back to idle
      wb(1'b1, `VPOS_A_CTRL, 32'h2);
      rchk(`VPOS_A_STAT, 32'h2);
      $display("test internal run done");
      // drive-clock mode, rising then falling edge
      for (int p = 0; p < 2; p++) begin
         load(3, 20'h0_0800);
         for (int i = 0; i < 3; i++) exp_q.push_back(v[i]);
         wb(1'b1, `VPOS_A_CTRL, ctl(2'h0, 1'b1, ~p[0], 1'b0, 1'b1));
         partner.frame(3);
         @(posedge core_clk);
         wait_stat(0, 1'b1);
         chk({39'h0, rd[0]}, 40'h1);
         chk(40'(exp_q.size()), 40'h0);
      end
      $display("test drive clock done");
      report_and_stop;
   end
endmodule
